// >>> logic/mgc_top.sv
// management port, nibble clocking, carrier and collision logic of the phy
// How it works
// - management clock limited to a few system cycles per half period
// - shared data line, 32 devices, 5-bit address
// - preamble is 32 ones over 32 clocks
// - ignore frames until preamble; resync on errors
// - frame starts with zero then one
// - nobody drives first read turnaround bit
// - read: drive zero, then 16 data bits
// - 32 register addresses; status and phy control decoded, others read zero
// - status bit 6 reports preamble suppression
// - strap pins captured into control bits 4:0
// - only strapped address zero isolates
// - isolate: ignore transmit, float mii outputs
// - nibble clocks 2.5 or 25 MHz
// - nibbles qualified by valid, error, enable
// - half duplex: collision when both active
// - full duplex: collision never reported
// - 10 Mb transmit: report after seven bits
// - collision during receive reported at once
// - heartbeat pulse after each 10 Mb transmit
// - receive carrier from squelch or detect
// - half duplex carrier includes transmit
// - carrier drops at end of packet
`timescale 1ns/1ns
module mgc_top #(
    parameter logic [15:0] STS_OTHER = mgc_pkg::STS_RST
) (
    input  wire logic            sys_clk_i,
    input  wire logic            nrst_i,
    input  wire logic            mdc_i,
    input  wire logic            mdio_i,
    output logic                 mdio_o,
    output logic                 mdio_oe_o,
    input  wire logic [4:0]      address_strap_pins_i,
    input  wire logic            speed100_i,
    input  wire logic            duplex_full_i,
    input  wire logic            heartbeat_en_i,
    input  wire logic            squelch_ok_i,
    input  wire logic            signal_detect_i,
    input  wire logic            zeros_seen_i,
    input  wire logic            rx_eop_i,
    input  wire logic            rx_in_valid_i,
    input  wire mgc_pkg::mgc_nib_t rx_in_word_i,
    output logic                 rx_in_ready_o,
    input  wire logic            tx_en_i,
    output logic                 tx_act_o,
    output logic [3:0]           rxd_o,
    output logic                 rx_dv_o,
    output logic                 rx_er_o,
    output logic                 crs_o,
    output logic                 col_o,
    output logic                 rx_clk_o,
    output logic                 tx_clk_o,
    output logic                 mii_oe_o,
    output logic                 isolate_o
);
    typedef struct packed {
        logic                   mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2;
        logic [4:0]             strap_s1, strap_s2;
        logic                   txen_s1, txen_s2;
        logic                   cap_pend, iso;
        logic [4:0]             phy_addr;
        logic [5:0]             ones;
        logic                   synced;
        mgc_pkg::mgc_mst_t      mst;
        logic [4:0]             bcnt;
        logic                   rd, hit;
        logic [4:0]             regad;
        logic [15:0]            sh;
        logic                   mdio_oe, mdio_do;
        logic                   rx_act, tx_act, col_raw, col_dly, col, rx_prev;
        logic [1:0]             bdiv;
        logic [2:0]             col_bits;
        logic                   hb_wait, sqe;
        logic [4:0]             hb_cnt;
        logic [2:0]             ndiv;
        logic                   nclk;
        mgc_pkg::mgc_nib_t [1:0] fifo;
        logic [1:0]             fcnt;
        logic                   wp, rp;
        mgc_pkg::mgc_nib_t      rxo;
        logic                   dv;
    } mgc_st_t;

    mgc_st_t st_r;
    mgc_st_t st_nxt;

    localparam int NCLK_HALF = mgc_pkg::NCLK_HALF;

    logic rise, b, tick, push, pop, raw;

    function automatic logic [15:0] rdata(input logic [4:0] a, input logic [4:0] pa);
        logic [15:0] v;
        v = 16'h0000;
        if (a == mgc_pkg::REG_STATUS) begin
            v = STS_OTHER;
            v[mgc_pkg::STS_NOPRE] = 1'b1;
        end else if (a == mgc_pkg::REG_PHYCTL) begin
            v = {11'h000, pa};
        end
        return v;
    endfunction

    // edge found from the twice-synchronised clock, so the clock limit is
    // a few system cycles per half period, not the full 25 MHz
    assign rise = st_r.mdc_s2 & ~st_r.mdc_s3;
    assign b    = st_r.mdio_s2;
    assign tick = speed100_i | (st_r.ndiv == 3'(NCLK_HALF - 1) & ~st_r.nclk);
    assign push = rx_in_valid_i & rx_in_ready_o;
    assign pop  = tick & (st_r.fcnt != 2'h0);
    assign raw  = ~duplex_full_i & st_r.rx_act & st_r.tx_act;
    assign rx_in_ready_o = (st_r.fcnt != 2'h2) | tick;

    always_comb begin
        st_nxt = st_r;
        st_nxt.mdc_s1   = mdc_i;
        st_nxt.mdc_s2   = st_r.mdc_s1;
        st_nxt.mdc_s3   = st_r.mdc_s2;
        st_nxt.mdio_s1  = mdio_i;
        st_nxt.mdio_s2  = st_r.mdio_s1;
        st_nxt.strap_s1 = address_strap_pins_i;
        st_nxt.strap_s2 = st_r.strap_s1;
        st_nxt.txen_s1  = tx_en_i;
        st_nxt.txen_s2  = st_r.txen_s1;

        if (st_r.cap_pend) begin
            st_nxt.cap_pend = 1'b0;
            st_nxt.phy_addr = st_r.strap_s2;
            st_nxt.iso      = (st_r.strap_s2 == 5'h00);
        end

        if (rise) begin
            case (st_r.mst)
                mgc_pkg::M_IDLE: begin
                    if (b) begin
                        if (st_r.ones != 6'(mgc_pkg::PRE_BITS)) begin
                            st_nxt.ones = st_r.ones + 6'h01;
                        end
                        // the 32nd one completes the preamble, not a 33rd
                        if (st_r.ones >= 6'(mgc_pkg::PRE_BITS - 1)) begin
                            st_nxt.synced = 1'b1;
                        end
                    end else begin
                        st_nxt.ones = 6'h00;
                        if (st_r.synced) begin
                            st_nxt.mst = mgc_pkg::M_ST;
                        end
                    end
                end
                mgc_pkg::M_ST: begin
                    st_nxt.bcnt = 5'h00;
                    if (b) begin
                        st_nxt.mst = mgc_pkg::M_OP;
                    end else begin
                        st_nxt.synced = 1'b0;
                        st_nxt.mst    = mgc_pkg::M_IDLE;
                    end
                end
                mgc_pkg::M_OP: begin
                    st_nxt.sh   = {st_r.sh[14:0], b};
                    st_nxt.bcnt = st_r.bcnt + 5'h01;
                    if (st_r.bcnt == 5'h01) begin
                        st_nxt.bcnt = 5'h00;
                        st_nxt.rd   = ({st_r.sh[0], b} == mgc_pkg::OP_RD);
                        if ({st_r.sh[0], b} == mgc_pkg::OP_RD || {st_r.sh[0], b} == mgc_pkg::OP_WR) begin
                            st_nxt.mst = mgc_pkg::M_PHY;
                        end else begin
                            st_nxt.synced = 1'b0;
                            st_nxt.mst    = mgc_pkg::M_IDLE;
                        end
                    end
                end
                mgc_pkg::M_PHY, mgc_pkg::M_REG: begin
                    st_nxt.sh   = {st_r.sh[14:0], b};
                    st_nxt.bcnt = st_r.bcnt + 5'h01;
                    if (st_r.bcnt == 5'h04) begin
                        st_nxt.bcnt = 5'h00;
                        if (st_r.mst == mgc_pkg::M_PHY) begin
                            st_nxt.hit = ({st_r.sh[3:0], b} == st_r.phy_addr);
                            st_nxt.mst = mgc_pkg::M_REG;
                        end else begin
                            st_nxt.regad = {st_r.sh[3:0], b};
                            st_nxt.mst   = mgc_pkg::M_TA;
                        end
                    end
                end
                mgc_pkg::M_TA: begin
                    if (st_r.bcnt == 5'h00) begin
                        st_nxt.bcnt = 5'h01;
                        if (!st_r.rd && !b) begin
                            st_nxt.synced = 1'b0;
                            st_nxt.mst    = mgc_pkg::M_IDLE;
                        end else if (st_r.rd && st_r.hit) begin
                            st_nxt.mdio_oe = 1'b1;
                            st_nxt.mdio_do = 1'b0;
                        end
                    end else begin
                        st_nxt.bcnt = 5'h00;
                        if (!st_r.rd && b) begin
                            st_nxt.synced = 1'b0;
                            st_nxt.mst    = mgc_pkg::M_IDLE;
                        end else begin
                            st_nxt.mst     = mgc_pkg::M_DAT;
                            st_nxt.sh      = rdata(st_r.regad, st_r.phy_addr);
                            st_nxt.mdio_do = st_nxt.sh[15];
                        end
                    end
                end
                mgc_pkg::M_DAT: begin
                    st_nxt.sh      = {st_r.sh[14:0], b};
                    st_nxt.mdio_do = st_r.sh[14];
                    st_nxt.bcnt    = st_r.bcnt + 5'h01;
                    if (st_r.bcnt == 5'h0F) begin
                        st_nxt.mdio_oe = 1'b0;
                        st_nxt.mst     = mgc_pkg::M_IDLE;
                        // address field writable, isolate stays with the strap
                        if (!st_r.rd && st_r.hit && st_r.regad == mgc_pkg::REG_PHYCTL) begin
                            st_nxt.phy_addr = {st_r.sh[3:0], b};
                        end
                    end
                end
                default: begin
                    st_nxt.mst = mgc_pkg::M_IDLE;
                end
            endcase
        end

        // receive carrier, cleared by end of packet
        if (rx_eop_i) begin
            st_nxt.rx_act = 1'b0;
        end else if (speed100_i ? (signal_detect_i & zeros_seen_i) : squelch_ok_i) begin
            st_nxt.rx_act = 1'b1;
        end
        st_nxt.tx_act = st_r.txen_s2 & ~st_r.iso;
        // one cycle of history tells which side was active first
        st_nxt.rx_prev = st_r.rx_act;

        // collision qualification
        st_nxt.col_raw = raw;
        if (raw && !st_r.col_raw) begin
            // receive arriving during a 10 Mb transmit means a delayed report
            st_nxt.col_dly  = ~speed100_i & ~st_r.rx_prev;
            st_nxt.col_bits = 3'h0;
            st_nxt.bdiv     = 2'h0;
        end else if (raw && st_r.col_dly && st_r.col_bits != mgc_pkg::COL_BITS) begin
            st_nxt.bdiv = st_r.bdiv + 2'h1;
            if (st_r.bdiv == 2'(mgc_pkg::BIT_CYC - 1)) begin
                st_nxt.bdiv     = 2'h0;
                st_nxt.col_bits = st_r.col_bits + 3'h1;
            end
        end

        // heartbeat after transmit end
        if (st_r.tx_act && !st_nxt.tx_act && heartbeat_en_i && !speed100_i) begin
            st_nxt.hb_wait = 1'b1;
            st_nxt.hb_cnt  = 5'(mgc_pkg::HB_DLY_CYC - 1);
        end else if (st_r.hb_cnt != 5'h00) begin
            st_nxt.hb_cnt = st_r.hb_cnt - 5'h01;
        end else if (st_r.hb_wait) begin
            st_nxt.hb_wait = 1'b0;
            st_nxt.sqe     = 1'b1;
            st_nxt.hb_cnt  = 5'(mgc_pkg::SQE_CYC - 1);
        end else begin
            st_nxt.sqe = 1'b0;
        end

        st_nxt.col = ~duplex_full_i & ((raw & (~st_nxt.col_dly | st_nxt.col_bits == mgc_pkg::COL_BITS))
                     | st_r.sqe);

        // 10 Mb nibble clock divider
        st_nxt.ndiv = st_r.ndiv + 3'h1;
        if (st_r.ndiv == 3'(NCLK_HALF - 1)) begin
            st_nxt.ndiv = 3'h0;
            st_nxt.nclk = ~st_r.nclk;
        end

        // two-entry receive buffer, drained once per nibble clock
        if (push) begin
            st_nxt.fifo[st_r.wp] = rx_in_word_i;
            st_nxt.wp            = ~st_r.wp;
        end
        if (pop) begin
            st_nxt.rp = ~st_r.rp;
        end
        st_nxt.fcnt = st_r.fcnt + {1'b0, push} - {1'b0, pop};
        if (tick) begin
            st_nxt.dv  = pop;
            st_nxt.rxo = pop ? st_r.fifo[st_r.rp] : '0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            st_r          <= '0;
            st_r.mst      <= mgc_pkg::M_IDLE;
            st_r.cap_pend <= 1'b1;
            // synchronisers keep running so the strap is settled at release
            st_r.strap_s1 <= st_nxt.strap_s1;
            st_r.strap_s2 <= st_nxt.strap_s2;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign mdio_o    = st_r.mdio_do;
    assign mdio_oe_o = st_r.mdio_oe;
    assign tx_act_o  = st_r.tx_act;
    assign rxd_o     = st_r.rxo.nib;
    assign rx_dv_o   = st_r.dv;
    assign rx_er_o   = st_r.rxo.err;
    assign crs_o     = st_r.rx_act | (~duplex_full_i & st_r.tx_act);
    assign col_o     = st_r.col;
    // at 100 Mb the system clock itself is the nibble clock
    assign rx_clk_o  = speed100_i ? sys_clk_i : st_r.nclk;
    assign tx_clk_o  = rx_clk_o;
    assign mii_oe_o  = ~st_r.iso;
    assign isolate_o = st_r.iso;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    a_write_no_drive: assert property (st_r.mst == mgc_pkg::M_DAT && !st_r.rd |-> !mdio_oe_o)
        else $error("driven during write");
    a_ta1_float: assert property (st_r.mst == mgc_pkg::M_TA && st_r.bcnt == 5'h00 |-> !mdio_oe_o)
        else $error("first turnaround driven");
    a_ta2_zero: assert property ($rose(mdio_oe_o) |-> !mdio_o && st_r.mst == mgc_pkg::M_TA && st_r.hit)
        else $error("turnaround not zero");
    a_presync_idle: assert property (!st_r.synced && !$past(st_r.synced) |-> st_r.mst == mgc_pkg::M_IDLE)
        else $error("frame taken unsynced");
    a_status_bit6: assert property (mdio_oe_o && st_r.mst == mgc_pkg::M_DAT && st_r.bcnt == 5'h09
        && st_r.regad == mgc_pkg::REG_STATUS |-> mdio_o)
        else $error("status bit 6 low");
    a_strap_capture: assert property ($fell(st_r.cap_pend) |-> st_r.phy_addr == $past(st_r.strap_s2))
        else $error("strap not captured");
    a_iso_stable: assert property (!$past(st_r.cap_pend) |-> $stable(st_r.iso))
        else $error("isolate changed");
    a_iso_float: assert property (st_r.iso |-> !mii_oe_o && !tx_act_o)
        else $error("isolate drives mii");
    a_full_nocol: assert property (duplex_full_i && $past(duplex_full_i) |-> !col_o)
        else $error("collision in full duplex");
    a_col_delay: assert property (col_o && st_r.col_dly && st_r.col_raw |-> st_r.col_bits == mgc_pkg::COL_BITS)
        else $error("collision reported early");
    a_crs_full: assert property (duplex_full_i && !st_r.rx_act |-> !crs_o)
        else $error("carrier from transmit");
    a_sqe_len: assert property ($rose(st_r.sqe) |-> st_r.sqe [*8])
        else $error("heartbeat too short");
endmodule

// >>> logic/mgc_pkg.sv
// constants and types of the management port and carrier logic
package mgc_pkg;
    localparam int        CLK_NS      = 40;
    localparam int        PRE_BITS    = 32;
    localparam logic [4:0] REG_STATUS = 5'h01;
    localparam logic [4:0] REG_PHYCTL = 5'h19;
    localparam int        STS_NOPRE   = 6;
    localparam logic [15:0] STS_RST   = 16'h0000;
    localparam logic [1:0] OP_RD      = 2'h2;
    localparam logic [1:0] OP_WR      = 2'h1;
    localparam int        BIT_NS      = 100;
    localparam int        BIT_CYC     = (BIT_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0] COL_BITS   = 3'h7;
    localparam int        HB_DLY_NS   = 1000;
    localparam int        HB_DLY_CYC  = HB_DLY_NS / CLK_NS;
    localparam int        SQE_NS      = 10 * BIT_NS;
    localparam int        SQE_CYC     = SQE_NS / CLK_NS;
    localparam int        NCLK10_NS   = 400;
    localparam int        NCLK_HALF   = NCLK10_NS / 2 / CLK_NS;

    typedef enum logic [6:0] {
        M_IDLE = 7'h01,
        M_ST   = 7'h02,
        M_OP   = 7'h04,
        M_PHY  = 7'h08,
        M_REG  = 7'h10,
        M_TA   = 7'h20,
        M_DAT  = 7'h40
    } mgc_mst_t;

    typedef struct packed {
        logic       err;
        logic [3:0] nib;
    } mgc_nib_t;
endpackage

// >>> verification/mgc_sta_model.sv
// station manager model: management clock and data line driver
`timescale 1ns/1ns
module mgc_sta_model (
    input  wire logic sys_clk_i,
    input  wire logic mdio_i,
    output logic      mdc_o,
    output logic      mdio_o,
    output logic      mdio_oe_o
);
    initial begin
        mdc_o = 1'b0;
        mdio_o = 1'b1;
        mdio_oe_o = 1'b0;
    end
    // 320 ns per bit, well below the rate limit; clock idles low between frames
    task automatic bit_io(input logic v, input logic drv, output logic s);
        mdio_o <= v;
        mdio_oe_o <= drv;
        repeat (4) @(posedge sys_clk_i);
        mdc_o <= 1'b1;
        // sample mid high phase, the device moves its bit 3 clocks after the rise
        repeat (2) @(posedge sys_clk_i);
        s = mdio_i;
        repeat (2) @(posedge sys_clk_i);
        mdc_o <= 1'b0;
    endtask
    // released line, the pull-up supplies the 32 ones
    task automatic pre();
        logic s;
        for (int i = 0; i < 32; i++) bit_io(1'b1, 1'b0, s);
    endtask
    // rd returns the second turnaround bit above the 16 data bits
    task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [16:0] rd);
        logic [13:0] hdr;
        logic        wop;
        logic        s;
        hdr = {2'b01, op, pa, ra};
        wop = (op != mgc_pkg::OP_RD);
        for (int i = 13; i >= 0; i--) bit_io(hdr[i], 1'b1, s);
        bit_io(1'b1, wop, s); // read leaves first turnaround undriven
        bit_io(1'b0, wop, s);
        rd[16] = s;
        for (int i = 15; i >= 0; i--) begin
            bit_io(wd[i], wop, s);
            rd[i] = s;
        end
        bit_io(1'b1, 1'b0, s); // idle bit between frames
    endtask
endmodule

// >>> verification/test_mgc_top.sv
// self-checking bench for the management port, nibble and carrier logic
`timescale 1ns/1ns
module test_mgc_top;
    logic              sys_clk, nrst, mdc, sta_do, sta_oe, dev_do, dev_oe, in_rdy, tx_act;
    logic              spd100, dfull, hb_en, sq_ok, sd, zs, eop, in_vld, tx_en, mon, full;
    logic              rx_dv, rx_er, crs, col, rx_clk, tx_clk, mii_oe, iso;
    logic [3:0]        rxd;
    logic [4:0]        strap;
    logic [16:0]       r;
    logic [4:0]        rxq[$];
    logic [4:0]        exp_w[4] = '{5'h05, 5'h13, 5'h0A, 5'h0C};
    mgc_pkg::mgc_nib_t in_word;
    wire logic         mdio_w;
    time               t0;
    int                err_total = 0;
    int                comparisons = 0;

    // pull-up wins whenever nobody drives the line
    assign mdio_w = dev_oe ? dev_do : (sta_oe ? sta_do : 1'b1);

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    mgc_sta_model sta (.sys_clk_i(sys_clk), .mdio_i(mdio_w), .mdc_o(mdc), .mdio_o(sta_do), .mdio_oe_o(sta_oe));

    mgc_top uut (
        .sys_clk_i(sys_clk), .nrst_i(nrst), .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(dev_do),
        .mdio_oe_o(dev_oe), .address_strap_pins_i(strap), .speed100_i(spd100), .duplex_full_i(dfull),
        .heartbeat_en_i(hb_en), .squelch_ok_i(sq_ok), .signal_detect_i(sd), .zeros_seen_i(zs),
        .rx_eop_i(eop), .rx_in_valid_i(in_vld), .rx_in_word_i(in_word), .rx_in_ready_o(in_rdy),
        .tx_en_i(tx_en), .tx_act_o(tx_act), .rxd_o(rxd), .rx_dv_o(rx_dv), .rx_er_o(rx_er),
        .crs_o(crs), .col_o(col), .rx_clk_o(rx_clk), .tx_clk_o(tx_clk), .mii_oe_o(mii_oe), .isolate_o(iso)
    );

    // mid-nibble sampling, clear of the update point
    always @(negedge rx_clk) begin
        if (mon && rx_dv === 1'b1) rxq.push_back({rx_er, rxd});
    end

    task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic rd(input logic [4:0] pa, input logic [4:0] ra, input logic [16:0] e, input string nm);
        sta.xfer(mgc_pkg::OP_RD, pa, ra, 16'h0000, r);
        chk(nm, e, r);
    endtask
    task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd);
        sta.xfer(mgc_pkg::OP_WR, pa, ra, wd, r);
    endtask
    // word held until ready is seen high at an edge
    task automatic push(input logic [4:0] w);
        int n;
        in_vld <= 1'b1;
        in_word <= w;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (in_rdy !== 1'b1) full = 1'b1;
        end while (in_rdy !== 1'b1 && n < 50);
    endtask
    task automatic test_done();
        if (err_total == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        test_done();
    end

    initial begin
        {nrst, spd100, dfull, hb_en, sq_ok, sd, zs, eop, in_vld, tx_en, mon, full} = '0;
        strap = 5'h0A;
        in_word = '0;
        cyc(4);
        nrst <= 1'b1;
        cyc(2);
        rd(5'h0A, mgc_pkg::REG_STATUS, 17'h1FFFF, "before preamble");
        sta.pre();
        rd(5'h0A, mgc_pkg::REG_STATUS, 17'h00040, "status");
        rd(5'h0A, mgc_pkg::REG_PHYCTL, 17'h0000A, "strap address");
        rd(5'h0A, 5'h03, 17'h00000, "unmapped register");
        rd(5'h0B, mgc_pkg::REG_STATUS, 17'h1FFFF, "other address");
        wr(5'h0A, mgc_pkg::REG_PHYCTL, 16'h0000);
        chk("isolate by write", 17'h0, {16'h0, iso});
        rd(5'h00, mgc_pkg::REG_PHYCTL, 17'h00000, "written address");
        wr(5'h00, mgc_pkg::REG_PHYCTL, 16'h000A);
        wr(5'h0A, mgc_pkg::REG_STATUS, 16'hFFFF);
        rd(5'h0A, mgc_pkg::REG_STATUS, 17'h00040, "status read-only");
        sta.xfer(2'h0, 5'h0A, mgc_pkg::REG_STATUS, 16'h0000, r);
        rd(5'h0A, mgc_pkg::REG_STATUS, 17'h1FFFF, "after bad opcode");
        sta.pre();
        rd(5'h0A, mgc_pkg::REG_STATUS, 17'h00040, "resync");
        // 100 Mb carrier and collision
        spd100 <= 1'b1;
        tx_en <= 1'b1;
        cyc(8);
        chk("crs transmit half", 17'h1, {16'h0, crs});
        dfull <= 1'b1;
        cyc(2);
        chk("crs transmit full", 17'h0, {16'h0, crs});
        sd <= 1'b1;
        zs <= 1'b1;
        cyc(8);
        chk("crs receive", 17'h1, {16'h0, crs});
        chk("col full duplex", 17'h0, {16'h0, col});
        dfull <= 1'b0;
        cyc(4);
        chk("col half duplex", 17'h1, {16'h0, col});
        {sd, zs, eop, tx_en} <= 4'h2;
        cyc(1);
        eop <= 1'b0;
        cyc(8);
        chk("crs after end", 17'h0, {16'h0, crs});
        // 10 Mb, transmit first, then receive first, then heartbeat
        spd100 <= 1'b0;
        tx_en <= 1'b1;
        cyc(10);
        sq_ok <= 1'b1;
        cyc(12);
        chk("col held off", 17'h0, {16'h0, col});
        cyc(20);
        chk("col seven bits", 17'h1, {16'h0, col});
        {sq_ok, eop, tx_en} <= 3'h2;
        cyc(1);
        eop <= 1'b0;
        cyc(60);
        sq_ok <= 1'b1;
        cyc(4);
        tx_en <= 1'b1;
        cyc(6);
        chk("col receive first", 17'h1, {16'h0, col});
        {sq_ok, eop, tx_en} <= 3'h2;
        cyc(1);
        eop <= 1'b0;
        cyc(80);
        hb_en <= 1'b1;
        tx_en <= 1'b1;
        cyc(20);
        tx_en <= 1'b0;
        cyc(15);
        chk("sqe wait", 17'h0, {16'h0, col});
        cyc(25);
        chk("sqe pulse", 17'h1, {16'h0, col});
        cyc(30);
        chk("sqe end", 17'h0, {16'h0, col});
        // nibble stream through the buffer, third word must wait
        hb_en <= 1'b0;
        @(posedge rx_clk);
        t0 = $time;
        @(posedge rx_clk);
        chk("nibble clock period", 17'd400, 17'($time - t0));
        @(posedge tx_clk);
        t0 = $time;
        @(posedge tx_clk);
        chk("transmit clock period", 17'd400, 17'($time - t0));
        cyc(1);
        mon <= 1'b1;
        foreach (exp_w[i]) push(exp_w[i]);
        in_vld <= 1'b0;
        cyc(60);
        chk("buffer refused", 17'h1, {16'h0, full});
        chk("nibble count", 17'd4, 17'(rxq.size()));
        if (rxq.size() == 4) foreach (exp_w[i]) chk("nibble", {12'h0, exp_w[i]}, {12'h0, rxq[i]});
        chk("valid after drain", 17'h0, {16'h0, rx_dv});
        // strapped zero isolates, management still answers
        nrst <= 1'b0;
        strap <= 5'h00;
        cyc(4);
        nrst <= 1'b1;
        cyc(3);
        chk("isolate strapped", 17'h1, {16'h0, iso});
        chk("mii released", 17'h0, {16'h0, mii_oe});
        tx_en <= 1'b1;
        cyc(6);
        chk("transmit ignored", 17'h0, {16'h0, tx_act});
        tx_en <= 1'b0;
        sta.pre();
        rd(5'h00, mgc_pkg::REG_PHYCTL, 17'h00000, "isolate answers");
        test_done();
    end
endmodule
